//--- fcc_defs.svh
// offsets, field positions, reset values and counts of the framer control
`ifndef FCC_DEFS_SVH
`define FCC_DEFS_SVH
`define FCC_ADDR_CTRL6 8'h1E
`define FCC_ADDR_CTRL7 8'h0A
`define FCC_CTRL6_RST 8'h00
`define FCC_CTRL7_RST 8'h00
`define FCC_RDATA_RST 8'h00
`define FCC_UNMAPPED 8'h00
`define FCC_BIT_CRC_VARIANT 7
`define FCC_BIT_RX_ALIGN 6
`define FCC_BIT_TX_ALIGN 5
`define FCC_MON_MSB 4
`define FCC_MON_LSB 0
`define FCC_BIT_LOOPBACK 6
`define FCC_BIT_RX_RESET 5
`define FCC_BIT_TX_RESET 4
`define FCC_CTRL7_USED 8'h70
`define FCC_SEP_W 6
`define FCC_HALF_FRAME 6'h0C
`define FCC_NUM_CMD 4
`endif

//--- fcc_pkg.sv
// types of the framer common control block
package fcc_pkg;
  typedef logic [4:0] fcc_chan_t;
  typedef enum logic [0:0] {FCC_IDLE, FCC_PEND} fcc_cmd_state_t;
  typedef struct packed {
    logic level_d;
    logic bp_s1;
    logic bp_s2;
    logic bp_s3;
    fcc_cmd_state_t state;
    logic pulse;
  } fcc_cmd_reg_t;
  typedef struct packed {
    logic [7:0] ctrl6;
    logic [7:0] ctrl7;
    logic [7:0] rdata;
    logic tx_pos;
    logic tx_neg;
    logic [7:0] mon_data;
  } fcc_top_reg_t;
endpackage

//--- fcc_cmd_sync.sv
// one store command: edge detect, then a pulse on the backplane clock edge
`timescale 1ns/1ps
`include "fcc_defs.svh"
module fcc_cmd_sync (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_level,
  input wire logic i_bpclk,
  input wire logic i_gate,
  output logic o_pulse
);
  import fcc_pkg::*;
  fcc_cmd_reg_t r;
  fcc_cmd_reg_t next_r;
  logic bp_rise;

  always_comb begin
    next_r = r;
    next_r.level_d = i_level;
    next_r.bp_s1 = i_bpclk;
    next_r.bp_s2 = r.bp_s1;
    next_r.bp_s3 = r.bp_s2;
    next_r.pulse = 1'b0;
    bp_rise = r.bp_s2 & ~r.bp_s3;
    case (r.state)
      FCC_IDLE: begin
        // only a 0 to 1 change of the level arms the command
        if (i_level && !r.level_d) begin
          next_r.state = FCC_PEND;
        end
      end
      FCC_PEND: begin
        // issued on a store clock edge so the store sees it in its own time
        if (bp_rise) begin
          next_r.pulse = i_gate;
          next_r.state = FCC_IDLE;
        end
      end
      default: begin
        next_r.state = FCC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_pulse = r.pulse;

  ////////////////////////////////////////////////////////////////////////////
  sequence armed_s;
    i_level && !r.level_d && r.state == FCC_IDLE;
  endsequence
  sequence issued_s;
    r.state == FCC_PEND && r.bp_s2 && !r.bp_s3 && i_gate;
  endsequence

  pulse_single_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_pulse |=> !o_pulse)
    else $error("command pulse longer than one cycle");
  arm_then_fire_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    armed_s ##1 issued_s |=> o_pulse)
    else $error("armed command not issued on store clock edge");
  gate_block_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_pulse) |-> $past(i_gate) && $past(r.state) == FCC_PEND)
    else $error("pulse issued while gated off or unarmed");
endmodule

//--- fcc_control.sv
// common control registers six and seven of one framer
`timescale 1ns/1ps
`include "fcc_defs.svh"
module fcc_control (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_rx_backplane_clock,
  input wire logic i_tx_backplane_clock,
  input wire logic [`FCC_SEP_W-1:0] i_rx_store_sep,
  input wire logic [`FCC_SEP_W-1:0] i_tx_store_sep,
  output logic o_rx_store_align,
  output logic o_tx_store_align,
  output logic o_rx_store_reset,
  output logic o_tx_store_reset,
  output logic o_rx_crc_variant_select,
  output fcc_pkg::fcc_chan_t o_rx_monitor_sel,
  input wire fcc_pkg::fcc_chan_t i_rx_chan_num,
  input wire logic [7:0] i_rx_chan_data,
  input wire logic i_rx_chan_valid,
  output logic [7:0] o_rx_monitor_data_reg,
  output logic o_remote_loopback_enable,
  input wire logic i_rx_line_positive,
  input wire logic i_rx_line_negative,
  input wire logic i_fmt_line_positive,
  input wire logic i_fmt_line_negative,
  output logic o_tx_line_positive,
  output logic o_tx_line_negative
);
  import fcc_pkg::*;
  fcc_top_reg_t r;
  fcc_top_reg_t next_r;
  logic [`FCC_NUM_CMD-1:0] cmd_level;
  logic [`FCC_NUM_CMD-1:0] cmd_bpclk;
  logic [`FCC_NUM_CMD-1:0] cmd_gate;
  logic [`FCC_NUM_CMD-1:0] cmd_pulse;
  logic loop_en;

  ////////////////////////////////////////////////////////////////////////////
  // register port and datapath
  assign loop_en = r.ctrl7[`FCC_BIT_LOOPBACK];

  always_comb begin
    next_r = r;
    if (i_wr && i_addr == `FCC_ADDR_CTRL6) begin
      next_r.ctrl6 = i_wdata;
    end
    // unused positions are not stored, so they read back as zero
    if (i_wr && i_addr == `FCC_ADDR_CTRL7) begin
      next_r.ctrl7 = i_wdata & `FCC_CTRL7_USED;
    end
    if (i_rd) begin
      if (i_addr == `FCC_ADDR_CTRL6) begin
        next_r.rdata = r.ctrl6;
      end else if (i_addr == `FCC_ADDR_CTRL7) begin
        next_r.rdata = r.ctrl7;
      end else begin
        next_r.rdata = `FCC_UNMAPPED;
      end
    end
    // copy the selected channel's byte as it passes
    if (i_rx_chan_valid &&
        i_rx_chan_num == r.ctrl6[`FCC_MON_MSB:`FCC_MON_LSB]) begin
      next_r.mon_data = i_rx_chan_data;
    end
    // loopback replaces the formatter; receive side keeps framing
    if (loop_en) begin
      next_r.tx_pos = i_rx_line_positive;
      next_r.tx_neg = i_rx_line_negative;
    end else begin
      next_r.tx_pos = i_fmt_line_positive;
      next_r.tx_neg = i_fmt_line_negative;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      r.ctrl6 <= `FCC_CTRL6_RST;
      r.ctrl7 <= `FCC_CTRL7_RST;
      r.rdata <= `FCC_RDATA_RST;
      r.tx_pos <= 1'b0;
      r.tx_neg <= 1'b0;
      r.mon_data <= 8'h00;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // elastic store commands: 0 rx align, 1 tx align, 2 rx reset, 3 tx reset
  always_comb begin
    cmd_level[0] = r.ctrl6[`FCC_BIT_RX_ALIGN];
    cmd_level[1] = r.ctrl6[`FCC_BIT_TX_ALIGN];
    cmd_level[2] = r.ctrl7[`FCC_BIT_RX_RESET];
    cmd_level[3] = r.ctrl7[`FCC_BIT_TX_RESET];
    cmd_bpclk[0] = i_rx_backplane_clock;
    cmd_bpclk[1] = i_tx_backplane_clock;
    cmd_bpclk[2] = i_rx_backplane_clock;
    cmd_bpclk[3] = i_tx_backplane_clock;
    // align only acts below half a frame; the store then disrupts data
    cmd_gate[0] = i_rx_store_sep < `FCC_HALF_FRAME;
    cmd_gate[1] = i_tx_store_sep < `FCC_HALF_FRAME;
    // a reset always acts; the store drops data while it recentres
    cmd_gate[2] = 1'b1;
    cmd_gate[3] = 1'b1;
  end

  // a reset bit left high arms nothing more, as only edges count
  generate
    for (genvar g = 0; g < `FCC_NUM_CMD; g++) begin : g_cmd
      fcc_cmd_sync u_cmd (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_level(cmd_level[g]),
        .i_bpclk(cmd_bpclk[g]),
        .i_gate(cmd_gate[g]),
        .o_pulse(cmd_pulse[g])
      );
    end
  endgenerate

  assign o_rx_store_align = cmd_pulse[0];
  assign o_tx_store_align = cmd_pulse[1];
  assign o_rx_store_reset = cmd_pulse[2];
  assign o_tx_store_reset = cmd_pulse[3];
  assign o_rdata = r.rdata;
  assign o_rx_crc_variant_select = r.ctrl6[`FCC_BIT_CRC_VARIANT];
  assign o_rx_monitor_sel = r.ctrl6[`FCC_MON_MSB:`FCC_MON_LSB];
  assign o_rx_monitor_data_reg = r.mon_data;
  assign o_remote_loopback_enable = loop_en;
  assign o_tx_line_positive = r.tx_pos;
  assign o_tx_line_negative = r.tx_neg;

  ////////////////////////////////////////////////////////////////////////////
  sequence wr6_s;
    i_wr && i_addr == `FCC_ADDR_CTRL6;
  endsequence
  sequence wr7_s;
    i_wr && i_addr == `FCC_ADDR_CTRL7;
  endsequence

  crc_select_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    wr6_s |=> o_rx_crc_variant_select == $past(i_wdata[7]))
    else $error("crc variant select not taken from write");
  monitor_sel_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    wr6_s |=> o_rx_monitor_sel == $past(i_wdata[4:0]))
    else $error("monitor select not taken from write");
  monitor_copy_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_rx_chan_valid && i_rx_chan_num == o_rx_monitor_sel
    |=> o_rx_monitor_data_reg == $past(i_rx_chan_data))
    else $error("selected channel byte not copied");
  loop_enable_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    wr7_s |=> o_remote_loopback_enable == $past(i_wdata[6]))
    else $error("loopback enable not taken from write");
  loop_path_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_remote_loopback_enable ##1 o_remote_loopback_enable
    |-> o_tx_line_positive == $past(i_rx_line_positive)
        && o_tx_line_negative == $past(i_rx_line_negative))
    else $error("loopback does not return receive line");
  fmt_path_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !o_remote_loopback_enable ##1 !o_remote_loopback_enable
    |-> o_tx_line_positive == $past(i_fmt_line_positive))
    else $error("formatter not on line without loopback");
  align_gate_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_rx_store_align) |-> $past(i_rx_store_sep) < 6'h0C)
    else $error("rx align issued with half frame separation");
  // master leaves one idle cycle between a write and the next transfer
  ctrl7_read_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    wr7_s ##1 !i_wr ##1 (i_rd && i_addr == `FCC_ADDR_CTRL7 && !i_wr)
    |=> o_rdata == ($past(i_wdata, 3) & 8'h70))
    else $error("control seven readback wrong");
endmodule

//--- fcc_backplane_model.sv
// backplane clock model for the framer control bench
`timescale 1ns/1ps
module fcc_backplane_model (
  input wire logic i_clk,
  input wire logic i_run,
  output logic o_rx_clk,
  output logic o_tx_clk
);
  int cnt = 0;
  initial begin
    o_rx_clk = 1'b0;
    o_tx_clk = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // periods of 6 and 10 cycles, so the two backplane clocks rise together only once every 30 cycles
  always @(posedge i_clk) begin
    cnt <= cnt + 1;
    if (i_run && cnt % 3 == 0)
      o_rx_clk <= ~o_rx_clk;
    if (i_run && cnt % 5 == 0)
      o_tx_clk <= ~o_tx_clk;
  end
endmodule

//--- test_fcc_control.sv
// self-checking bench of the framer common control registers
`timescale 1ns/1ps
`include "fcc_defs.svh"
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin \
  fail_count++; \
  $display("unexpected %s: expected %0h seen %0h", nm, e, s); end end
module test_fcc_control;
  import fcc_pkg::*;
  logic i_clk = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic run = 1'b0, cvalid = 1'b0, rxp = 1'b0, rxn = 1'b0;
  logic fp = 1'b0, fn = 1'b0, rxclk, txclk;
  logic [7:0] addr = 8'h00, wdata = 8'h00, cdata = 8'h00, rdata, mon;
  logic [5:0] rsep = 6'h00, tsep = 6'h00;
  fcc_chan_t chan = 5'h00;
  fcc_chan_t sel;
  logic ra, ta, rr, tr, crc, lb, txp, txn;
  int fail_count = 0, checked = 0, cyc = 0;
  // four-state counts, so an unknown pulse level cannot pass as zero
  logic [7:0] n [4];
  always #5 i_clk = ~i_clk;
  fcc_backplane_model i_fcc_backplane_model (.i_clk(i_clk), .i_run(run),
    .o_rx_clk(rxclk), .o_tx_clk(txclk));
  fcc_control i_fcc_control (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(rdata), .i_rx_backplane_clock(rxclk),
    .i_tx_backplane_clock(txclk), .i_rx_store_sep(rsep),
    .i_tx_store_sep(tsep), .o_rx_store_align(ra), .o_tx_store_align(ta),
    .o_rx_store_reset(rr), .o_tx_store_reset(tr),
    .o_rx_crc_variant_select(crc), .o_rx_monitor_sel(sel),
    .i_rx_chan_num(chan), .i_rx_chan_data(cdata),
    .i_rx_chan_valid(cvalid), .o_rx_monitor_data_reg(mon),
    .o_remote_loopback_enable(lb), .i_rx_line_positive(rxp),
    .i_rx_line_negative(rxn), .i_fmt_line_positive(fp),
    .i_fmt_line_negative(fn), .o_tx_line_positive(txp),
    .o_tx_line_negative(txn));
  ////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // pulse counts per command output; a pulse longer than one cycle shows
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    n[0] <= n[0] + ra;
    n[1] <= n[1] + ta;
    n[2] <= n[2] + rr;
    n[3] <= n[3] + tr;
    if (cyc == 2000) begin
      fail_count++;
      give_verdict;
    end
  end
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask
  // write, wait out the slowest backplane period, count every pulse
  task cmd(input logic [7:0] a, input logic [7:0] d, input logic [3:0] e);
    n = '{default: 0};
    wr(a, d);
    repeat (40) @(posedge i_clk);
    #1;
    for (int k = 0; k < 4; k++)
      `CHK("pulses", e[k], n[k])
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    n = '{default: 0};
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    run <= 1'b1;
    rd(`FCC_ADDR_CTRL6, `FCC_CTRL6_RST);
    rd(`FCC_ADDR_CTRL7, `FCC_CTRL7_RST);
    wr(`FCC_ADDR_CTRL6, 8'h9F);
    `CHK("crc", 1'b1, crc)
    `CHK("sel", 5'h1F, sel)
    rd(`FCC_ADDR_CTRL6, 8'h9F);
    // follows a nonzero read, so stale read data would show
    rd(8'h33, `FCC_UNMAPPED);
    // software keeps the unassigned positions at zero
    wr(`FCC_ADDR_CTRL7, 8'h40);
    rd(`FCC_ADDR_CTRL7, 8'h40);
    `CHK("lb", 1'b1, lb)
    @(posedge i_clk);
    rxp <= 1'b1;
    fn <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    `CHK("txp", 1'b1, txp)
    `CHK("txn", 1'b0, txn)
    wr(`FCC_ADDR_CTRL7, 8'h00);
    @(posedge i_clk);
    #1;
    `CHK("lb", 1'b0, lb)
    `CHK("txn", 1'b1, txn)
    $display("registers and loopback done");
    wr(`FCC_ADDR_CTRL6, 8'h05);
    `CHK("crc", 1'b0, crc)
    @(posedge i_clk);
    chan <= 5'h05;
    cdata <= 8'hA5;
    cvalid <= 1'b1;
    @(posedge i_clk);
    chan <= 5'h06;
    cdata <= 8'h11;
    @(posedge i_clk);
    cvalid <= 1'b0;
    #1;
    `CHK("mon", 8'hA5, mon)
    $display("channel monitor done");
    cmd(`FCC_ADDR_CTRL6, 8'h40, 4'b0001);
    cmd(`FCC_ADDR_CTRL6, 8'h40, 4'b0000);
    cmd(`FCC_ADDR_CTRL6, 8'h00, 4'b0000);
    cmd(`FCC_ADDR_CTRL6, 8'h20, 4'b0010);
    @(posedge i_clk);
    rsep <= `FCC_HALF_FRAME;
    tsep <= `FCC_HALF_FRAME;
    cmd(`FCC_ADDR_CTRL6, 8'h00, 4'b0000);
    cmd(`FCC_ADDR_CTRL6, 8'h60, 4'b0000);
    @(posedge i_clk);
    rsep <= `FCC_HALF_FRAME - 6'h01;
    cmd(`FCC_ADDR_CTRL6, 8'h00, 4'b0000);
    cmd(`FCC_ADDR_CTRL6, 8'h60, 4'b0001);
    cmd(`FCC_ADDR_CTRL7, 8'h20, 4'b0100);
    cmd(`FCC_ADDR_CTRL7, 8'h00, 4'b0000);
    cmd(`FCC_ADDR_CTRL7, 8'h10, 4'b1000);
    cmd(`FCC_ADDR_CTRL7, 8'h00, 4'b0000);
    $display("store commands done");
    give_verdict;
  end
endmodule
